// [verilog/bmls_seq.sv]
// What this block does
// - after every system reset the first core runs the mask loader code first
// - on power-on only, straps are captured into the mode register after the rom stage
// - on system reset straps are ignored and the mode register keeps value
// - loader copied from the selected source into 256 KB on-chip memory
// - finally execution jumps to the copied first stage loader
// - processor units configured first, then fabric only if bitstream present
// - after fabric, application loaded and execution handed to it
// - boot source is memory card, quad flash or jtag from the straps
// - in jtag mode the core waits until a host has loaded software
// - after jtag load host may release to run or single step
// - host may configure the fabric over jtag without the processor
// - default cascaded chain exposes processor side and fabric together
// - split jumper gives independent mode, only fabric on the chain
module bmls_seq #(
  parameter int AW = bmls_pkg::CHIP_MEM_AW,
  parameter int SETTLE_CYC = bmls_pkg::POR_SETTLE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic [2:0] strap_i,
  input wire logic chain_split_jumper_i,
  input wire logic src_valid_i,
  input wire logic [31:0] src_data_i,
  input wire logic src_last_i,
  input wire logic src_image_ok_i,
  input wire logic has_bitstream_i,
  input wire logic fabric_done_i,
  input wire logic app_done_i,
  input wire logic proc_cfg_done_i,
  input wire logic jtag_loaded_i,
  input wire logic jtag_release_i,
  input wire logic jtag_step_i,
  input wire logic jtag_fabric_cfg_i,
  output logic src_ready_o,
  output logic [1:0] src_sel_o,
  output logic [1:0] mode_o,
  output logic [3:0] stage_o,
  output logic core_run_o,
  output logic step_pulse_o,
  output logic fabric_cfg_en_o,
  output logic jtag_fabric_en_o,
  output logic chain_proc_visible_o,
  output logic boot_error_o,
  output logic [31:0] mem_rdata_o
);
  // refuse sizes that the address and settle counters cannot serve
  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("bmls_seq: AW out of range");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65536) begin : g_bad_settle
    $error("bmls_seq: SETTLE_CYC out of range");
  end

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    bmls_pkg::bmls_state_t st;
    logic [AW-1:0] addr;
    logic [15:0] cnt;
    logic cold;
    logic err;
    logic step;
    logic split;
  } bmls_seq_t;

  bmls_seq_t s_q, s_d;
  logic [1:0] mode_q, mode_d;
  logic mode_valid_q;
  bmls_mem_if #(.AW(AW)) mif ();

  bmls_chip_mem #(.AW(AW)) u_mem (
    .sys_clk_i(sys_clk_i),
    .port(mif.mem)
  );

  // decode jumper strap into a boot mode
  function automatic logic [1:0] strap_to_mode(input logic [2:0] s);
    if (s == bmls_pkg::STRAP_RIGHT_PAIR) begin
      strap_to_mode = bmls_pkg::MODE_MEMORY_CARD;
    end else if (s == bmls_pkg::STRAP_CENTRE_PAIR) begin
      strap_to_mode = bmls_pkg::MODE_QUAD_FLASH;
    end else begin
      strap_to_mode = bmls_pkg::MODE_JTAG;
    end
  endfunction

  // ****************************************
  // mode register on power-on reset only
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      mode_q <= bmls_pkg::MODE_RESET_VAL;
      mode_valid_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      mode_valid_q <= mode_valid_q | (s_q.st == bmls_pkg::BMLS_LATCH);
    end
  end

  // capture straps only in the latch state of a cold start
  always_comb begin
    mode_d = mode_q;
    if (s_q.st == bmls_pkg::BMLS_LATCH) begin
      mode_d = strap_to_mode(strap_i);
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.step = 1'b0;
    case (s_q.st)
      bmls_pkg::BMLS_IDLE: begin
        s_d.st = bmls_pkg::BMLS_ROM;
        s_d.cnt = '0;
      end
      bmls_pkg::BMLS_ROM: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt >= 16'(SETTLE_CYC - 1)) begin
          s_d.cnt = '0;
          s_d.split = chain_split_jumper_i;
          if (s_q.cold) begin
            s_d.st = bmls_pkg::BMLS_LATCH;
          end else if (mode_q == bmls_pkg::MODE_JTAG) begin
            s_d.st = bmls_pkg::BMLS_JTAG_WAIT;
          end else begin
            s_d.st = bmls_pkg::BMLS_COPY;
          end
        end
      end
      bmls_pkg::BMLS_LATCH: begin
        s_d.cold = 1'b0;
        if (mode_d == bmls_pkg::MODE_JTAG) begin
          s_d.st = bmls_pkg::BMLS_JTAG_WAIT;
        end else begin
          s_d.st = bmls_pkg::BMLS_COPY;
        end
      end
      bmls_pkg::BMLS_COPY: begin
        if (src_valid_i) begin
          s_d.addr = s_q.addr + 1'b1;
          if (!src_image_ok_i) begin
            s_d.err = 1'b1;
            s_d.st = bmls_pkg::BMLS_JTAG_HALT;
          end else if (src_last_i || (&s_q.addr)) begin
            s_d.st = bmls_pkg::BMLS_HANDOFF;
          end
        end
      end
      bmls_pkg::BMLS_HANDOFF: begin
        s_d.st = bmls_pkg::BMLS_PSCFG;
      end
      bmls_pkg::BMLS_PSCFG: begin
        if (proc_cfg_done_i) begin
          s_d.st = has_bitstream_i ? bmls_pkg::BMLS_FABRIC : bmls_pkg::BMLS_APPLOAD;
        end
      end
      bmls_pkg::BMLS_FABRIC: begin
        if (fabric_done_i) begin
          s_d.st = bmls_pkg::BMLS_APPLOAD;
        end
      end
      bmls_pkg::BMLS_APPLOAD: begin
        if (app_done_i) begin
          s_d.st = bmls_pkg::BMLS_RUN;
        end
      end
      bmls_pkg::BMLS_JTAG_WAIT: begin
        if (jtag_loaded_i) begin
          s_d.st = bmls_pkg::BMLS_JTAG_HALT;
        end
      end
      bmls_pkg::BMLS_JTAG_HALT: begin
        if (!s_q.err && jtag_release_i) begin
          s_d.st = bmls_pkg::BMLS_RUN;
        end else if (!s_q.err && jtag_step_i) begin
          s_d.step = 1'b1;
        end
      end
      bmls_pkg::BMLS_RUN: begin
        s_d.st = bmls_pkg::BMLS_RUN;
      end
      default: begin
        s_d.st = bmls_pkg::BMLS_IDLE;
      end
    endcase
    // a restart after a completed latch is a warm start
    if (mode_valid_q && s_q.st == bmls_pkg::BMLS_IDLE) begin
      s_d.cold = 1'b0;
    end
  end

  // system reset restarts the sequence; cold flag survives only through por
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: bmls_pkg::BMLS_IDLE, addr: '0, cnt: '0, cold: 1'b1, err: 1'b0, step: 1'b0, split: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // memory port and outputs
  // ****************************************
  assign mif.we = (s_q.st == bmls_pkg::BMLS_COPY) && src_valid_i && src_image_ok_i;
  assign mif.addr = s_q.addr;
  assign mif.wdata = src_data_i;
  assign mem_rdata_o = mif.rdata;
  assign src_ready_o = (s_q.st == bmls_pkg::BMLS_COPY);
  assign src_sel_o = mode_q;
  assign mode_o = mode_q;
  assign stage_o = s_q.st;
  assign core_run_o = (s_q.st == bmls_pkg::BMLS_RUN) || s_q.step;
  assign step_pulse_o = s_q.step;
  assign fabric_cfg_en_o = (s_q.st == bmls_pkg::BMLS_FABRIC);
  assign jtag_fabric_en_o = jtag_fabric_cfg_i;
  assign chain_proc_visible_o = !s_q.split;
  assign boot_error_o = s_q.err;

  // ****************************************
  // checks
  // ****************************************
  sequence s_fabric_then_app;
    (s_q.st == bmls_pkg::BMLS_FABRIC) ##1 (s_q.st == bmls_pkg::BMLS_APPLOAD);
  endsequence
  sequence s_idle_then_rom;
    (s_q.st == bmls_pkg::BMLS_IDLE) ##1 (s_q.st == bmls_pkg::BMLS_ROM);
  endsequence

  // first sampled edge after release still shows idle, then rom follows
  property p_rom_first;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> s_idle_then_rom;
  endproperty
  a_rom_first: assert property (p_rom_first) else $error("release did not pass through rom");
  property p_start_rom;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rst_n_i && s_q.st == bmls_pkg::BMLS_IDLE) |=> (s_q.st == bmls_pkg::BMLS_ROM);
  endproperty
  a_start_rom: assert property (p_start_rom) else $error("idle did not enter rom");
  property p_latch_cold;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.st == bmls_pkg::BMLS_LATCH) |=> (mode_q == $past(strap_to_mode(strap_i)));
  endproperty
  a_latch_cold: assert property (p_latch_cold) else $error("mode not latched");
  property p_keep_mode;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.st != bmls_pkg::BMLS_LATCH) |=> $stable(mode_q);
  endproperty
  a_keep_mode: assert property (p_keep_mode) else $error("mode changed outside latch");
  property p_no_write_out;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      mif.we |-> (s_q.st == bmls_pkg::BMLS_COPY);
  endproperty
  a_no_write_out: assert property (p_no_write_out) else $error("memory write outside copy");
  property p_handoff;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.st == bmls_pkg::BMLS_HANDOFF) |=> (s_q.st == bmls_pkg::BMLS_PSCFG);
  endproperty
  a_handoff: assert property (p_handoff) else $error("handoff lost");
  property p_fabric_gate;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.st == bmls_pkg::BMLS_PSCFG && proc_cfg_done_i && !has_bitstream_i) |=> !fabric_cfg_en_o;
  endproperty
  a_fabric_gate: assert property (p_fabric_gate) else $error("fabric loaded without bitstream");
  property p_app_after;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.st == bmls_pkg::BMLS_FABRIC && fabric_done_i) |-> s_fabric_then_app;
  endproperty
  a_app_after: assert property (p_app_after) else $error("app not after fabric");
  property p_jtag_wait;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.st == bmls_pkg::BMLS_JTAG_WAIT) |-> !core_run_o;
  endproperty
  a_jtag_wait: assert property (p_jtag_wait) else $error("core ran while waiting");
  property p_split;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.st == bmls_pkg::BMLS_ROM && s_d.st != bmls_pkg::BMLS_ROM) |=>
        (chain_proc_visible_o == !$past(chain_split_jumper_i));
  endproperty
  a_split: assert property (p_split) else $error("chain split wrong");
endmodule

// [verilog/bmls_pkg.sv]
package bmls_pkg;
  // ****************************************
  // boot mode encodings
  // ****************************************
  localparam logic [1:0] MODE_MEMORY_CARD = 2'h0;
  localparam logic [1:0] MODE_QUAD_FLASH = 2'h1;
  localparam logic [1:0] MODE_JTAG = 2'h2;
  localparam logic [1:0] MODE_RESET_VAL = 2'h2;
  // jumper pin-pair positions on the strap bus
  localparam int STRAP_W = 3;
  localparam logic [2:0] STRAP_RIGHT_PAIR = 3'h1;
  localparam logic [2:0] STRAP_CENTRE_PAIR = 3'h2;
  localparam logic [2:0] STRAP_LEFT_PAIR = 3'h4;
  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int CHIP_MEM_BYTES = 262144;
  localparam int CHIP_MEM_WORDS = CHIP_MEM_BYTES / 4;
  localparam int CHIP_MEM_AW = 16;
  localparam int CLK_MHZ = 40;
  localparam int POR_SETTLE_NS = 100;
  localparam int POR_SETTLE_CYC = (POR_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    BMLS_IDLE = 4'b0000,
    BMLS_ROM = 4'b0001,
    BMLS_LATCH = 4'b0010,
    BMLS_COPY = 4'b0011,
    BMLS_HANDOFF = 4'b0100,
    BMLS_PSCFG = 4'b0101,
    BMLS_FABRIC = 4'b0110,
    BMLS_APPLOAD = 4'b0111,
    BMLS_RUN = 4'b1000,
    BMLS_JTAG_WAIT = 4'b1001,
    BMLS_JTAG_HALT = 4'b1010
  } bmls_state_t;
endpackage

// [verilog/bmls_mem_if.sv]
interface bmls_mem_if #(parameter int AW = 16) ();
  // on-chip memory write port and registered read
  logic we;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// [verilog/bmls_ocm.sv]
module bmls_chip_mem #(
  parameter int AW = 16
) (
  input wire logic sys_clk_i,
  bmls_mem_if.mem port
);
  logic [31:0] mem_q [0:(1<<AW)-1];
  logic [31:0] rdata_q;
  // ****************************************
  // single port memory, registered read
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    rdata_q <= mem_q[port.addr];
  end
  assign port.rdata = rdata_q;
endmodule

// [dv/bmls_src_model.sv]
// ****************************************
// boot source partner: streams loader words
// ****************************************
module bmls_src_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic src_ready_i,
  input wire logic slow_i,
  input wire logic bad_i,
  input wire logic [7:0] len_i,
  output logic src_valid_o,
  output logic [31:0] src_data_o,
  output logic src_last_o,
  output logic src_image_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic gap_q;
  logic [31:0] word;
  // pointer moves only on an accepted word; slow mode idles a cycle after each
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      gap_q <= 1'h0;
    end else if (src_valid_o && src_ready_i) begin
      cnt_q <= cnt_q + 8'h01;
      gap_q <= slow_i;
    end else begin
      gap_q <= 1'h0;
    end
  end
  // words held until taken; idle data and image-ok lines show the inverse, last shows pointer bit 0, so stale data never looks valid
  assign word = {16'ha5a5, 8'h00, cnt_q};
  assign src_valid_o = (cnt_q < len_i) && !gap_q;
  assign src_data_o = src_valid_o ? word : ~word;
  assign src_last_o = src_valid_o ? (cnt_q == len_i - 8'h01) : cnt_q[0];
  assign src_image_ok_o = src_valid_o ? !bad_i : bad_i;
endmodule

// [dv/test_boot_mode_latch_sequencer.sv]
// ****************************************
// boot sequencer testbench
// ****************************************
module test_boot_mode_latch_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rst_n = 1'h0, por_n = 1'h0, split = 1'h0, bits = 1'h0, fab_done = 1'h0;
  logic app_done = 1'h0, proc_done = 1'h0, jt_load = 1'h0, jt_rel = 1'h0, jt_step = 1'h0, jt_fab = 1'h0;
  logic slow = 1'h0, bad = 1'h0;
  logic [2:0] strap = bmls_pkg::STRAP_RIGHT_PAIR;
  logic [7:0] len = 8'h04;
  logic s_valid, s_last, s_ok, s_ready, core_run, step_p, fab_en, jt_fab_en, proc_vis, boot_err;
  logic [31:0] s_data;
  logic [31:0] mem_rd;
  logic [1:0] src_sel, mode;
  logic [3:0] stage;
  int num_errors = 0, checks_done = 0;

  bmls_src_model i_src (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .src_ready_i(s_ready), .slow_i(slow),
    .bad_i(bad), .len_i(len), .src_valid_o(s_valid), .src_data_o(s_data), .src_last_o(s_last),
    .src_image_ok_o(s_ok));
  bmls_seq #(.SETTLE_CYC(1)) i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .por_n_i(por_n), .strap_i(strap),
    .chain_split_jumper_i(split), .src_valid_i(s_valid), .src_data_i(s_data), .src_last_i(s_last),
    .src_image_ok_i(s_ok), .has_bitstream_i(bits), .fabric_done_i(fab_done), .app_done_i(app_done),
    .proc_cfg_done_i(proc_done), .jtag_loaded_i(jt_load), .jtag_release_i(jt_rel), .jtag_step_i(jt_step),
    .jtag_fabric_cfg_i(jt_fab), .src_ready_o(s_ready), .src_sel_o(src_sel), .mode_o(mode),
    .stage_o(stage), .core_run_o(core_run), .step_pulse_o(step_p), .fabric_cfg_en_o(fab_en),
    .jtag_fabric_en_o(jt_fab_en), .chain_proc_visible_o(proc_vis), .boot_error_o(boot_err),
    .mem_rdata_o(mem_rd));

  // 40 MHz clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task wait_stage(input logic [3:0] s);
    int i;
    i = 0;
    while (stage !== s && i < 300) begin
      tick(1);
      i++;
    end
    check(stage, s);
  endtask

  // reset for 12 cycles, cold adds the power-on reset; straps and source setup applied meanwhile
  task start(input logic cold, input logic [2:0] st, input logic sl, input logic bd, input logic bt);
    @(posedge sys_clk);
    rst_n <= 1'h0;
    por_n <= !cold;
    strap <= st;
    slow <= sl;
    bad <= bd;
    bits <= bt;
    {fab_done, app_done, proc_done, jt_load, jt_rel, jt_step} <= 6'h00;
    tick(11);
    check(stage, bmls_pkg::BMLS_IDLE);
    @(posedge sys_clk);
    rst_n <= 1'h1;
    por_n <= 1'h1;
    wait_stage(bmls_pkg::BMLS_ROM);
  endtask

  task t_card_cold;
    start(1'h1, bmls_pkg::STRAP_RIGHT_PAIR, 1'h0, 1'h0, 1'h1);
    wait_stage(bmls_pkg::BMLS_COPY);
    check(mode, bmls_pkg::MODE_MEMORY_CARD);
    check(src_sel, bmls_pkg::MODE_MEMORY_CARD);
    wait_stage(bmls_pkg::BMLS_PSCFG);
    tick(5);
    check(stage, bmls_pkg::BMLS_PSCFG);
    check(fab_en, 1'h0);
    @(posedge sys_clk);
    proc_done <= 1'h1;
    wait_stage(bmls_pkg::BMLS_FABRIC);
    check(fab_en, 1'h1);
    @(posedge sys_clk);
    fab_done <= 1'h1;
    wait_stage(bmls_pkg::BMLS_APPLOAD);
    check(core_run, 1'h0);
    @(posedge sys_clk);
    app_done <= 1'h1;
    wait_stage(bmls_pkg::BMLS_RUN);
    check(core_run, 1'h1);
  endtask

  task t_warm_keep;
    start(1'h0, bmls_pkg::STRAP_CENTRE_PAIR, 1'h1, 1'h0, 1'h0);
    wait_stage(bmls_pkg::BMLS_COPY);
    check(mode, bmls_pkg::MODE_MEMORY_CARD);
    check(mem_rd, 32'ha5a5_0000);
    @(posedge sys_clk);
    proc_done <= 1'h1;
    wait_stage(bmls_pkg::BMLS_APPLOAD);
    @(posedge sys_clk);
    app_done <= 1'h1;
    wait_stage(bmls_pkg::BMLS_RUN);
  endtask

  task t_jtag;
    int n;
    n = 0;
    start(1'h1, bmls_pkg::STRAP_CENTRE_PAIR, 1'h0, 1'h0, 1'h0);
    wait_stage(bmls_pkg::BMLS_COPY);
    check(mode, bmls_pkg::MODE_QUAD_FLASH);
    start(1'h1, bmls_pkg::STRAP_LEFT_PAIR, 1'h0, 1'h0, 1'h0);
    wait_stage(bmls_pkg::BMLS_JTAG_WAIT);
    check(mode, bmls_pkg::MODE_JTAG);
    tick(8);
    check(stage, bmls_pkg::BMLS_JTAG_WAIT);
    check(core_run, 1'h0);
    @(posedge sys_clk);
    jt_load <= 1'h1;
    @(posedge sys_clk);
    jt_step <= 1'h1;
    @(posedge sys_clk);
    jt_step <= 1'h0;
    #1;
    repeat (6) begin
      if (step_p === 1'h1) n++;
      tick(1);
    end
    check(n, 1);
    @(posedge sys_clk);
    jt_rel <= 1'h1;
    wait_stage(bmls_pkg::BMLS_RUN);
    check(core_run, 1'h1);
    // warm restart in jtag mode must ignore the straps and wait again
    start(1'h0, bmls_pkg::STRAP_RIGHT_PAIR, 1'h0, 1'h0, 1'h0);
    wait_stage(bmls_pkg::BMLS_JTAG_WAIT);
    check(mode, bmls_pkg::MODE_JTAG);
    check(core_run, 1'h0);
  endtask

  task t_bad_image;
    start(1'h1, bmls_pkg::STRAP_RIGHT_PAIR, 1'h0, 1'h1, 1'h0);
    wait_stage(bmls_pkg::BMLS_JTAG_HALT);
    check(boot_err, 1'h1);
    tick(5);
    check(stage, bmls_pkg::BMLS_JTAG_HALT);
    check(core_run, 1'h0);
    // a host release is refused after a bad image
    @(posedge sys_clk);
    jt_rel <= 1'h1;
    tick(3);
    check(stage, bmls_pkg::BMLS_JTAG_HALT);
    check(core_run, 1'h0);
  endtask

  task t_chain;
    @(posedge sys_clk);
    split <= 1'h1;
    start(1'h0, bmls_pkg::STRAP_RIGHT_PAIR, 1'h0, 1'h0, 1'h0);
    wait_stage(bmls_pkg::BMLS_COPY);
    check(proc_vis, 1'h0);
    @(posedge sys_clk);
    jt_fab <= 1'h1;
    tick(1);
    check(jt_fab_en, 1'h1);
    @(posedge sys_clk);
    split <= 1'h0;
    jt_fab <= 1'h0;
    start(1'h0, bmls_pkg::STRAP_RIGHT_PAIR, 1'h0, 1'h0, 1'h0);
    wait_stage(bmls_pkg::BMLS_COPY);
    check(proc_vis, 1'h1);
    check(jt_fab_en, 1'h0);
  endtask

  task end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    t_card_cold();
    t_warm_keep();
    t_jtag();
    t_bad_image();
    t_chain();
    end_sim();
  end

  // watchdog, well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end
endmodule
